/* File: src/plr_pin_level_readback.sv */
/*
 * plr_pin_level_readback: live pin level register of an audio serial
 * port, with the function, direction and output-value registers that
 * decide whether each pin is driven as general-purpose output.
 * assumes: pins are two-way; the surrounding pad logic resolves each
 * wire from the output enable and returns its level on pins_in; all
 * inputs except pins_in are synchronous to core_clk_in.
 */
// Implementation choice: strobed register access.
// How it works
// - a read of the level register returns each pin's level two clocks before the read strobe
// - bits 31..25 show the seven clock, frame sync and mute pins
// - bits 15..0 show serial data pins, 1 high and 0 low
// - bits 24..16 always read back as zero
// - writes into bits 24..16 change nothing
// - after reset level bits follow the pins, no fixed value
// - pin driven from output bit only when function and direction set
`timescale 1ns/1ps
`default_nettype none

module plr_pin_level_readback (
   input  wire logic                           core_clk_in,
   input  wire logic                           rst_b_in,
   // register port
   input  wire logic [plr_pkg::PLR_ADDR_W-1:0] addr_in,
   input  wire logic [plr_pkg::PLR_DATA_W-1:0] wdata_in,
   input  wire logic                           wr_in,
   input  wire logic                           rd_in,
   output var  logic [plr_pkg::PLR_DATA_W-1:0] rdata_out,
   // pins: level seen, value driven, drive enable
   input  wire plr_pkg::plr_pins_s             pins_in,
   output var  plr_pkg::plr_pins_s             pins_out,
   output var  plr_pkg::plr_pins_s             pins_oe_out
);

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   typedef enum {
      PLR_SEL_NONE,
      PLR_SEL_FUNC,
      PLR_SEL_DIR,
      PLR_SEL_OUT,
      PLR_SEL_LEVEL,
      PLR_SEL_CHANGE
   } plr_sel_e;

   plr_sel_e                         sel;
   logic                             wr_func;
   logic                             wr_dir;
   logic                             wr_out;
   logic                             wr_change;
   plr_pkg::plr_pins_s               func_q;
   plr_pkg::plr_pins_s               dir_q;
   plr_pkg::plr_pins_s               outv_q;
   plr_pkg::plr_pins_s               level_sync;
   logic [plr_pkg::PLR_PIN_N-1:0]    level_prev_q;
   logic [plr_pkg::PLR_PIN_N-1:0]    change_q;
   logic [plr_pkg::PLR_PIN_N-1:0]    change_d;
   logic [plr_pkg::PLR_PIN_N-1:0]    change_clr;
   logic [plr_pkg::PLR_PIN_N-1:0]    change_set;
   logic [plr_pkg::PLR_PIN_N-1:0]    oe_vec;
   logic [plr_pkg::PLR_PIN_N-1:0]    drv_vec;
   logic [plr_pkg::PLR_DATA_W-1:0]   rdata_d;
   logic                             prev_valid_q;

   // -------------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------------
   always_comb begin
      case (addr_in)
         plr_pkg::PLR_OFS_FUNC: begin
            sel = PLR_SEL_FUNC;
         end
         plr_pkg::PLR_OFS_DIR: begin
            sel = PLR_SEL_DIR;
         end
         plr_pkg::PLR_OFS_OUT: begin
            sel = PLR_SEL_OUT;
         end
         plr_pkg::PLR_OFS_LEVEL: begin
            sel = PLR_SEL_LEVEL;
         end
         plr_pkg::PLR_OFS_CHANGE: begin
            sel = PLR_SEL_CHANGE;
         end
         default: begin
            sel = PLR_SEL_NONE;
         end
      endcase
   end

   // the level register is read-only: a write there, including its
   // reserved field, reaches no storage at all
   assign wr_func   = wr_in && (sel == PLR_SEL_FUNC);
   assign wr_dir    = wr_in && (sel == PLR_SEL_DIR);
   assign wr_out    = wr_in && (sel == PLR_SEL_OUT);
   assign wr_change = wr_in && (sel == PLR_SEL_CHANGE);

   // -------------------------------------------------------------------
   // software registers steering the pin drivers
   // -------------------------------------------------------------------
   // reserved bits of every word are dropped on write, so a stray one
   // from careless software cannot disturb the pins
   plr_field_reg u_func_reg (
      .clk_in   (core_clk_in),
      .rst_b_in (rst_b_in),
      .wr_in    (wr_func),
      .wdata_in (wdata_in),
      .val_out  (func_q)
   );

   plr_field_reg u_dir_reg (
      .clk_in   (core_clk_in),
      .rst_b_in (rst_b_in),
      .wr_in    (wr_dir),
      .wdata_in (wdata_in),
      .val_out  (dir_q)
   );

   plr_field_reg u_out_reg (
      .clk_in   (core_clk_in),
      .rst_b_in (rst_b_in),
      .wr_in    (wr_out),
      .wdata_in (wdata_in),
      .val_out  (outv_q)
   );

   // -------------------------------------------------------------------
   // pin drivers
   // -------------------------------------------------------------------
   // drive only in general-purpose output mode; other functions belong
   // to the serial engine, which is not part of this block
   assign oe_vec  = func_q & dir_q;
   assign drv_vec = outv_q;

   // registered so every pin output comes straight from a flip-flop;
   // costs one cycle between a register write and the pad
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pins_oe_out <= plr_pkg::plr_pins_s'(plr_pkg::PLR_PINS_RST);
      end else begin
         pins_oe_out <= plr_pkg::plr_pins_s'(oe_vec);
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pins_out <= plr_pkg::plr_pins_s'(plr_pkg::PLR_PINS_RST);
      end else begin
         pins_out <= plr_pkg::plr_pins_s'(drv_vec);
      end
   end

   // -------------------------------------------------------------------
   // pin level capture
   // -------------------------------------------------------------------
   // the pad level is sampled whatever function or direction is set;
   // the synchroniser has no reset so it tracks the pins through reset
   plr_sync2 #(
      .W (plr_pkg::PLR_PIN_N)
   ) u_level_sync (
      .clk_in   (core_clk_in),
      .async_in (pins_in),
      .sync_out (level_sync)
   );

   // -------------------------------------------------------------------
   // level change flags
   // -------------------------------------------------------------------
   // the previous level is not trusted until one sample after reset,
   // so the unknown power-up level raises no false change
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prev_valid_q <= 1'b0;
      end else begin
         prev_valid_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         level_prev_q <= plr_pkg::PLR_PINS_RST;
      end else begin
         level_prev_q <= level_sync;
      end
   end

   assign change_set = prev_valid_q ?
                       (level_prev_q ^ level_sync) : plr_pkg::PLR_PINS_RST;
   assign change_clr = wr_change ?
                       plr_pkg::PLR_PINS_RST ^ plr_pkg::plr_from_word(wdata_in)
                       : plr_pkg::PLR_PINS_RST;

   // write one to clear; a change in the clearing cycle still sticks
   always_comb begin
      change_d = (change_q & ~change_clr) | change_set;
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         change_q <= plr_pkg::PLR_PINS_RST;
      end else begin
         change_q <= change_d;
      end
   end

   // -------------------------------------------------------------------
   // read data
   // -------------------------------------------------------------------
   always_comb begin
      rdata_d = plr_pkg::PLR_WORD_ZERO;
      if (rd_in) begin
         case (sel)
            PLR_SEL_FUNC: begin
               rdata_d = plr_pkg::plr_to_word(func_q);
            end
            PLR_SEL_DIR: begin
               rdata_d = plr_pkg::plr_to_word(dir_q);
            end
            PLR_SEL_OUT: begin
               rdata_d = plr_pkg::plr_to_word(outv_q);
            end
            PLR_SEL_LEVEL: begin
               // control pins land in 31..25, data pins in 15..0 and
               // the reserved field is filled with zeros by the pack
               rdata_d = plr_pkg::plr_to_word(level_sync);
            end
            PLR_SEL_CHANGE: begin
               rdata_d = plr_pkg::plr_to_word(change_q);
            end
            default: begin
               rdata_d = plr_pkg::PLR_WORD_ZERO;
            end
         endcase
      end
   end

   // read data stand only in the cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_out <= plr_pkg::PLR_WORD_ZERO;
      end else begin
         rdata_out <= rdata_d;
      end
   end

endmodule : plr_pin_level_readback

`default_nettype wire

/* File: pkg/plr_pkg.sv */
/*
 * plr_pkg: constants, register offsets and pin bundle types for the
 * pin level readback block.
 * assumes: byte addresses on an 8-bit register port, 32-bit data words.
 */
`default_nettype none

package plr_pkg;

   // -------------------------------------------------------------------
   // bus geometry
   // -------------------------------------------------------------------
   localparam int unsigned PLR_ADDR_W = 8;
   localparam int unsigned PLR_DATA_W = 32;
   localparam int unsigned PLR_PIN_N  = 23;

   // -------------------------------------------------------------------
   // register offsets (byte addresses)
   // -------------------------------------------------------------------
   localparam logic [PLR_ADDR_W-1:0] PLR_OFS_FUNC   = 8'h10;
   localparam logic [PLR_ADDR_W-1:0] PLR_OFS_DIR    = 8'h14;
   localparam logic [PLR_ADDR_W-1:0] PLR_OFS_OUT    = 8'h18;
   localparam logic [PLR_ADDR_W-1:0] PLR_OFS_LEVEL  = 8'h1c;
   localparam logic [PLR_ADDR_W-1:0] PLR_OFS_CHANGE = 8'h20;

   // -------------------------------------------------------------------
   // field positions inside a register word
   // -------------------------------------------------------------------
   localparam int unsigned PLR_CTL_MSB  = 31;
   localparam int unsigned PLR_CTL_LSB  = 25;
   localparam int unsigned PLR_RSV_MSB  = 24;
   localparam int unsigned PLR_RSV_LSB  = 16;
   localparam int unsigned PLR_DATA_MSB = 15;
   localparam int unsigned PLR_DATA_LSB = 0;
   localparam int unsigned PLR_CTL_N    = PLR_CTL_MSB - PLR_CTL_LSB + 1;
   localparam int unsigned PLR_RSV_N    = PLR_RSV_MSB - PLR_RSV_LSB + 1;
   localparam int unsigned PLR_DATA_N   = PLR_DATA_MSB - PLR_DATA_LSB + 1;

   // -------------------------------------------------------------------
   // reset and fixed values
   // -------------------------------------------------------------------
   localparam logic [PLR_RSV_N-1:0]  PLR_RSV_VAL   = 9'h000;
   localparam logic [PLR_DATA_W-1:0] PLR_WORD_ZERO = 32'h0000_0000;
   localparam logic [PLR_PIN_N-1:0]  PLR_PINS_RST  = 23'h00_0000;

   // -------------------------------------------------------------------
   // pin bundle, msb first in register bit order
   // -------------------------------------------------------------------
   typedef struct packed {
      logic                  rx_frame_sync_pin;
      logic                  rx_high_clock_pin;
      logic                  rx_bit_clock_pin;
      logic                  tx_frame_sync_pin;
      logic                  tx_high_clock_pin;
      logic                  tx_bit_clock_pin;
      logic                  mute_out_pin;
      logic [PLR_DATA_N-1:0] serial_data_pin;
   } plr_pins_s;

   // -------------------------------------------------------------------
   // word <-> bundle; reserved field always comes back as its default
   // -------------------------------------------------------------------
   function automatic logic [PLR_DATA_W-1:0] plr_to_word(input plr_pins_s p);
      logic [PLR_PIN_N-1:0] b;
      b = p;
      return {b[PLR_PIN_N-1:PLR_DATA_N], PLR_RSV_VAL, b[PLR_DATA_N-1:0]};
   endfunction : plr_to_word

   function automatic plr_pins_s plr_from_word(
      input logic [PLR_DATA_W-1:0] w);
      return plr_pins_s'({w[PLR_CTL_MSB:PLR_CTL_LSB],
                          w[PLR_DATA_MSB:PLR_DATA_LSB]});
   endfunction : plr_from_word

endpackage : plr_pkg

`default_nettype wire

/* File: src/plr_sync2.sv */
/*
 * plr_sync2: two-stage level synchroniser for a bundle of pins.
 * assumes: inputs are plain levels; no reset, so the output follows
 * the pins from the first clocks onward rather than a fixed value.
 */
`timescale 1ns/1ps
`default_nettype none

module plr_sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_in,
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // first stage is read by the second stage only
   always_ff @(posedge clk_in) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
   end

endmodule : plr_sync2

`default_nettype wire

/* File: src/plr_field_reg.sv */
/*
 * plr_field_reg: software-written pin bundle register.
 * assumes: one-cycle write strobe qualified by address decode upstream.
 */
`timescale 1ns/1ps
`default_nettype none

module plr_field_reg (
   input  wire logic                          clk_in,
   input  wire logic                          rst_b_in,
   input  wire logic                          wr_in,
   input  wire logic [plr_pkg::PLR_DATA_W-1:0] wdata_in,
   output var  plr_pkg::plr_pins_s            val_out
);

   // reserved bits are dropped by the unpack, so they never store
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         val_out <= plr_pkg::plr_pins_s'(plr_pkg::PLR_PINS_RST);
      end else if (wr_in) begin
         val_out <= plr_pkg::plr_from_word(wdata_in);
      end
   end

endmodule : plr_field_reg

`default_nettype wire

/* File: tb/plr_pin_level_readback_sva.sv */
/*
 * plr_pin_level_readback_sva: port-level checks of the pin level block.
 * assumes: bound to plr_pin_level_readback; one clock, async low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module plr_pin_level_readback_sva (
   input wire logic               core_clk_in,
   input wire logic               rst_b_in,
   input wire logic [7:0]         addr_in,
   input wire logic [31:0]        wdata_in,
   input wire logic               wr_in,
   input wire logic               rd_in,
   input wire logic [31:0]        rdata_out,
   input wire plr_pkg::plr_pins_s pins_in,
   input wire plr_pkg::plr_pins_s pins_out,
   input wire plr_pkg::plr_pins_s pins_oe_out
);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence s_lvl_rd;
      rd_in && addr_in == 8'h1c;
   endsequence
   // pins held long enough to cross both synchroniser stages
   sequence s_pins_steady;
      pins_in == $past(pins_in) && $past(pins_in) == $past(pins_in, 2);
   endsequence

   chk_ctl_level: assert property (s_lvl_rd ##0 s_pins_steady |=>
      rdata_out[31:25] == $past(pins_in[22:16]))
      else $error("control pin levels misread");
   chk_data_level: assert property (s_lvl_rd ##0 s_pins_steady |=>
      rdata_out[15:0] == $past(pins_in[15:0]))
      else $error("data pin levels misread");
   // a change one cycle before the read must not show yet: one stage
   // alone would let it through
   chk_sync_delay: assert property (s_lvl_rd ##0
      ($past(pins_in) != $past(pins_in, 2) &&
       $past(pins_in, 2) == $past(pins_in, 3))
      |=> rdata_out[15:0] == $past(pins_in[15:0], 3))
      else $error("pin change seen before two stages");
   chk_rsv_zero: assert property (rdata_out[24:16] == 9'h000)
      else $error("reserved read bits not zero");
   chk_idle_zero: assert property (!rd_in |=> rdata_out == 32'h0000_0000)
      else $error("read data outside read cycle");
   chk_unmapped_zero: assert property (rd_in &&
      (addr_in < 8'h10 || addr_in > 8'h20) |=> rdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   // a stray store would reach the pins two edges later, so look there
   chk_lvl_wr_ign: assert property (wr_in && addr_in == 8'h1c &&
      !$past(wr_in) |-> ##2 pins_out == $past(pins_out, 2) &&
      pins_oe_out == $past(pins_oe_out, 2))
      else $error("level register write had effect");
   chk_func_off: assert property (wr_in && addr_in == 8'h10 &&
      wdata_in == 32'h0000_0000 |-> ##2 pins_oe_out == 23'h00_0000)
      else $error("pin driven without function bit");
   chk_out_copy: assert property (wr_in && addr_in == 8'h18 |->
      ##2 pins_out[15:0] == $past(wdata_in[15:0], 2))
      else $error("output value not driven");
endmodule : plr_pin_level_readback_sva

bind plr_pin_level_readback plr_pin_level_readback_sva i_chk (
   .core_clk_in (core_clk_in),
   .rst_b_in    (rst_b_in),
   .addr_in     (addr_in),
   .wdata_in    (wdata_in),
   .wr_in       (wr_in),
   .rd_in       (rd_in),
   .rdata_out   (rdata_out),
   .pins_in     (pins_in),
   .pins_out    (pins_out),
   .pins_oe_out (pins_oe_out)
);

`default_nettype wire

/* File: tb/plr_pin_level_readback_tb_top.sv */
/*
 * plr_pin_level_readback_tb_top: register-level bench for the pin level
 * block; the bench plays pad logic, resolving each pin from the enables.
 * assumes: checker bound separately; 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module plr_pin_level_readback_tb_top;
   // ----------------------------------------------------------------
   // bench
   // ----------------------------------------------------------------
   localparam logic [31:0] FUNC_W = 32'h8000_0003;
   localparam logic [31:0] DIR_W  = 32'h4000_0003;
   localparam logic [31:0] OUT_W  = 32'h8000_0002;
   logic                   core_clk_in;
   logic                   rst_b_in;
   logic [7:0]             addr_in;
   logic [31:0]            wdata_in;
   logic                   wr_in;
   logic                   rd_in;
   logic [31:0]            rdata_out;
   plr_pkg::plr_pins_s     pins_in, pins_out, pins_oe_out;
   logic [22:0]            ext_q;
   logic [22:0]            en_v;
   logic [31:0]            rd_v;
   logic [22:0]            pat [0:3] = '{23'h7f_ffff, 23'h00_0000,
                                         23'h2a_5555, 23'h40_0001};
   int                     bad_count = 0;
   int                     total_checks = 0;

   // released pins show the outside level, driven pins our value
   assign pins_in = plr_pkg::plr_pins_s'((pins_oe_out & pins_out) |
                                         (~pins_oe_out & ext_q));

   plr_pin_level_readback i_dut (
      .core_clk_in (core_clk_in),
      .rst_b_in    (rst_b_in),
      .addr_in     (addr_in),
      .wdata_in    (wdata_in),
      .wr_in       (wr_in),
      .rd_in       (rd_in),
      .rdata_out   (rdata_out),
      .pins_in     (pins_in),
      .pins_out    (pins_out),
      .pins_oe_out (pins_oe_out)
   );

   function automatic logic [31:0] lvl(input logic [22:0] p);
      return {p[22:16], 9'h000, p[15:0]};
   endfunction : lvl

   function automatic logic [22:0] to_p(input logic [31:0] w);
      return {w[31:25], w[15:0]};
   endfunction : to_p

   task automatic check(input string n, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge core_clk_in);
      wr_in    <= 1'b0;
   endtask : wr

   task automatic rd_chk(input string n, input logic [7:0] a,
                         input logic [31:0] exp);
      @(posedge core_clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge core_clk_in);
      rd_in   <= 1'b0;
      #1 check(n, rdata_out, exp);
   endtask : rd_chk

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   // a hang costs a mismatch and ends the run
   initial begin
      repeat (2000) @(posedge core_clk_in);
      bad_count++;
      stop_test();
   end

   initial begin
      rst_b_in = 1'b0;
      addr_in  = 8'h00;
      wdata_in = 32'h0000_0000;
      wr_in    = 1'b0;
      rd_in    = 1'b0;
      ext_q    = 23'h55_aaaa;
      repeat (3) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      rd_chk("level after reset", 8'h1c, lvl(23'h55_aaaa));
      for (int i = 0; i < 4; i++) begin
         ext_q <= pat[i];
         repeat (3) @(posedge core_clk_in);
         rd_chk("level word", 8'h1c, lvl(pat[i]));
      end
      // read one cycle after a pin change still sees the old level
      @(posedge core_clk_in);
      ext_q   <= 23'h15_aaaa;
      @(posedge core_clk_in);
      rd_in   <= 1'b1;
      addr_in <= 8'h1c;
      @(posedge core_clk_in);
      rd_in   <= 1'b0;
      #1 check("read at pin change", rdata_out, lvl(pat[3]));
      rd_chk("unmapped read", 8'hfc, 32'h0000_0000);
      wr(8'h1c, 32'hffff_ffff);
      wr(8'h10, 32'h01ff_0000);
      wr(8'h14, 32'h01ff_0000);
      rd_chk("reserved not stored", 8'h10, 32'h0000_0000);
      check("enables after writes", pins_oe_out, 32'h0000_0000);
      check("values after writes", pins_out, 32'h0000_0000);
      rd_chk("level kept", 8'h1c, lvl(23'h15_aaaa));
      wr(8'h10, FUNC_W);
      wr(8'h14, DIR_W);
      wr(8'h18, OUT_W);
      en_v = to_p(FUNC_W & DIR_W);
      repeat (2) @(posedge core_clk_in);
      #1 check("pin enables", pins_oe_out, en_v);
      check("pin values", pins_out, to_p(OUT_W));
      for (int k = 0; k < 2; k++) begin
         ext_q <= k ? 23'h00_0000 : 23'h7f_ffff;
         repeat (3) @(posedge core_clk_in);
         rd_chk("driven level", 8'h1c,
                lvl((en_v & to_p(OUT_W)) | (~en_v & ext_q)));
      end
      wr(8'h10, 32'h0000_0000);
      repeat (2) @(posedge core_clk_in);
      #1 check("released pins", pins_oe_out, 32'h0000_0000);
      wr(8'h10, FUNC_W);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      #1 check("enables in reset", pins_oe_out, 32'h0000_0000);
      @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      rd_chk("level after reset", 8'h1c, lvl(23'h00_0000));
      // change flags: set by a level change, write one to clear
      ext_q <= 23'h00_0005;
      repeat (3) @(posedge core_clk_in);
      rd_chk("change flags", 8'h20, lvl(23'h00_0005));
      wr(8'h20, 32'h0000_0001);
      rd_chk("change cleared", 8'h20, lvl(23'h00_0004));
      stop_test();
   end
endmodule : plr_pin_level_readback_tb_top

`default_nettype wire
